/* rtl/eec_top.sv */
// end-of-string / END control and accessory option registers
// How it works
// [R1] accessory write 100xxxxx loads eos control bits 4..2
// [R2] hardware or channel reset clears eos control
// [R3] width bit one compares all eight bits
// [R4] width bit zero compares low seven bits
// [R5] talker match with transmit flag drives EOI
// [R6] listener match with receive flag sets END
// [R7] receive match treated as EOI-terminated byte
// [R8] accessory write 101xxxxx loads option bits 4..0
// [R9] polarity bit selects interrupt pin active level
// [R10] listen-when-controller zero rejects own commands
// [R11] serial poll EOI follows the poll bit
// [R12] auto take-control on passed control
// [R13] other selectors leave eos control unchanged
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
module eec_top
   import eec_pkg::*;
(
   input  wire logic       core_clk,            // 25 MHz clock
   input  wire logic       resetn,              // async reset, low
   input  wire logic [2:0] reg_addr,            // register offset
   input  wire logic [7:0] reg_wdata,           // write data
   input  wire logic       reg_wr,              // write strobe
   input  wire logic       reg_rd,              // read strobe
   output logic      [7:0] reg_rdata,           // read data, next cycle
   input  wire logic       talker_active_state, // talker active
   input  wire logic       tx_load,             // byte from command_data_out sent
   input  wire logic [7:0] command_data_out,    // outgoing byte
   input  wire logic       tx_eoi_req,          // software EOI for byte
   input  wire logic       serial_poll_active,  // being serial polled
   output logic            eoi_out,             // EOI driven with byte
   input  wire logic       listener_active,     // listener addressed
   input  wire logic       rx_valid,            // byte received
   input  wire logic [7:0] rx_byte,             // received byte
   input  wire logic       rx_eoi,              // EOI seen with byte
   output logic            rx_end,              // byte ends message, pulse
   output logic            end_status,          // sticky END bit
   input  wire logic       int_request,         // internal interrupt level
   output logic            int_pin,             // interrupt pin
   input  wire logic       controller_in_charge,// acting as controller
   input  wire logic       own_command,         // command byte sourced here
   output logic            command_accept,      // accept command byte
   input  wire logic       control_passed,      // control passed to us, pulse
   output logic            take_control,        // take control, pulse
   input  wire logic       srq_state,           // service request state
   input  wire logic       parallel_poll_flag,  // parallel poll flag
   output logic            ist                  // individual status
);
   logic [2:0] eos_ctrl_reg;   // width, transmit match, receive match
   logic [4:0] options_reg;    // source, polarity, listen, poll eoi, take
   logic [7:0] eos_byte_reg;   // end_string_byte
   logic       tx_match;       // outgoing byte matches
   logic       rx_match;       // incoming byte matches
   logic       acc_wr;         // write to accessory port
   logic       chan_reset;     // channel_reset_command issued
   logic       end_set;        // END bit set event
   logic       end_clr;        // END bit read-clear
   logic [7:0] rdata_next;     // read data next value
   logic       width_sel;      // compare_width_select
   logic       tx_on_match;    // transmit_end_on_match
   logic       rx_on_match;    // receive_end_on_match

   // selector decode, used for both accessory registers
   function automatic logic acc_sel(input logic [7:0] d, input logic [2:0] sel);
      acc_sel = d[SEL_MSB:SEL_LSB] == sel;
   endfunction : acc_sel

   // strobe decode
   always_comb begin
      acc_wr = reg_wr && reg_addr == ACC_OFF;
      chan_reset  = reg_wr && reg_addr == AUX_OFF && reg_wdata == AUX_CHAN_RESET;
      width_sel   = eos_ctrl_reg[2];
      tx_on_match = eos_ctrl_reg[1];
      rx_on_match = eos_ctrl_reg[0];
   end

   // eos control register
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         eos_ctrl_reg <= EOS_CTRL_RST;                               // R2
      end else if (chan_reset) begin
         eos_ctrl_reg <= EOS_CTRL_RST;                               // R2
      end else if (acc_wr && acc_sel(reg_wdata, SEL_EOS_CTRL)) begin // R13
         eos_ctrl_reg <= reg_wdata[WIDTH_SEL_BIT:RX_MATCH_BIT];      // R1
      end
   end

   // option register; channel reset leaves it alone
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         options_reg <= OPTIONS_RST;
      end else if (acc_wr && acc_sel(reg_wdata, SEL_OPTIONS)) begin
         options_reg <= reg_wdata[STAT_SRC_BIT:AUTO_TAKE_BIT];       // R8
      end
   end

   // end-of-string byte
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         eos_byte_reg <= EOS_BYTE_RST;
      end else if (reg_wr && reg_addr == EOS_BYTE_OFF) begin
         eos_byte_reg <= reg_wdata;
      end
   end

   // comparators for both directions
   eec_eos_match u_tx_match (
      .data_byte (command_data_out),
      .eos_byte  (eos_byte_reg),
      .width8    (width_sel),
      .match     (tx_match)
   );
   eec_eos_match u_rx_match (
      .data_byte (rx_byte),
      .eos_byte  (eos_byte_reg),
      .width8    (width_sel),
      .match     (rx_match)
   );

   // EOI with outgoing byte; serial poll has its own setting
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         eoi_out <= 1'b0;
      end else if (serial_poll_active && tx_load) begin
         eoi_out <= options_reg[POLL_EOI_BIT];                       // R11
      end else if (tx_load) begin
         eoi_out <= tx_eoi_req || (talker_active_state && tx_on_match && tx_match); // R5
      end else begin
         eoi_out <= 1'b0;
      end
   end

   // end-of-message to acceptor
   always_comb begin
      end_set = rx_valid && listener_active && (rx_eoi || (rx_on_match && rx_match)); // R6 R7
      end_clr = reg_rd && reg_addr == STATUS_OFF;
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rx_end <= 1'b0;
      end else begin
         rx_end <= end_set;                                          // R7
      end
   end

   // sticky END status, set wins over read-clear
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         end_status <= 1'b0;
      end else if (end_set) begin
         end_status <= 1'b1;                                         // R6
      end else if (end_clr) begin
         end_status <= 1'b0;
      end
   end

   // interrupt pin polarity
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         int_pin <= 1'b1;
      end else begin
         int_pin <= options_reg[INT_POL_BIT] ? int_request : !int_request; // R9
      end
   end

   // own command bytes need listen-when-controller
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         command_accept <= 1'b1;
      end else begin
         command_accept <= !(controller_in_charge && own_command && !options_reg[LISTEN_CTL_BIT]); // R10
      end
   end

   // automatic take control
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         take_control <= 1'b0;
      end else begin
         take_control <= control_passed && options_reg[AUTO_TAKE_BIT]; // R12
      end
   end

   // individual status source
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ist <= 1'b0;
      end else begin
         ist <= options_reg[STAT_SRC_BIT] ? srq_state : parallel_poll_flag;
      end
   end

   // read mux
   always_comb begin
      rdata_next = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            STATUS_OFF:    rdata_next[END_STAT_BIT] = end_status;
            CTRL_READ_OFF: rdata_next = {eos_ctrl_reg, options_reg};
            default:       rdata_next = 8'h00;
         endcase
      end
   end

   // read data valid one cycle after strobe only
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= rdata_next;
      end
   end

   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   AST_ACC_A_LOAD: assert property (acc_wr && reg_wdata[7:5] == 3'h4 && !chan_reset
      |=> eos_ctrl_reg == $past(reg_wdata[4:2])) else $error("eos control not loaded"); // R1
   AST_CHAN_RESET: assert property (chan_reset |=> eos_ctrl_reg == 3'h0)
      else $error("channel reset did not clear eos control"); // R2
   AST_KEEP_OTHER: assert property (acc_wr && reg_wdata[7:5] != 3'h4 && !chan_reset
      |=> $stable(eos_ctrl_reg)) else $error("eos control changed by other selector"); // R13
   AST_TX_EOI_8: assert property (tx_load && !serial_poll_active && talker_active_state && tx_on_match
      && width_sel && command_data_out == eos_byte_reg |=> eoi_out) else $error("no EOI on 8-bit match"); // R3
   AST_TX_EOI_7: assert property (tx_load && !serial_poll_active && talker_active_state && tx_on_match
      && !width_sel && command_data_out[6:0] == eos_byte_reg[6:0] |=> eoi_out)
      else $error("no EOI on 7-bit match"); // R4
   AST_TX_NO_EOI: assert property (tx_load && !serial_poll_active && !tx_eoi_req
      && command_data_out[6:0] != eos_byte_reg[6:0] |=> !eoi_out) else $error("spurious EOI"); // R5
   AST_RX_END: assert property (rx_valid && listener_active && rx_on_match && rx_match
      |=> rx_end && end_status) else $error("END not flagged on match"); // R6
   AST_RX_AS_EOI: assert property (rx_valid && listener_active && !rx_eoi
      |=> rx_end == ($past(rx_on_match) && $past(rx_match))) else $error("match not treated as EOI"); // R7
   AST_OPT_LOAD: assert property (acc_wr && reg_wdata[7:5] == 3'h5
      |=> options_reg == $past(reg_wdata[4:0])) else $error("options not loaded"); // R8
   AST_INT_POL: assert property (##1 int_pin == ($past(options_reg[3]) ~^ $past(int_request)))
      else $error("interrupt polarity wrong"); // R9
   AST_LWC: assert property (controller_in_charge && own_command && !options_reg[2]
      |=> !command_accept) else $error("own command accepted"); // R10
   AST_SP_EOI: assert property (serial_poll_active && tx_load
      |=> eoi_out == $past(options_reg[1])) else $error("serial poll EOI wrong"); // R11
   AST_AUTO_TAKE_CONTROL: assert property (control_passed && options_reg[0] |=> take_control)
      else $error("control not taken"); // R12

   COV_TX_EOI: cover property (tx_load && talker_active_state && tx_on_match ##1 eoi_out);
   COV_RX_END: cover property (rx_valid && listener_active && rx_on_match && rx_match && !rx_eoi);
   COV_CHAN_RESET: cover property (eos_ctrl_reg != 3'h0 ##1 chan_reset);
   COV_SET_CLR: cover property (end_set && end_clr);
endmodule : eec_top

/* rtl/eec_pkg.sv */
// constants for the end-of-string and accessory option control block
package eec_pkg;
   // register port offsets (3-bit address)
   localparam logic [2:0] STATUS_OFF     = 3'h0;  // status read, end bit
   localparam logic [2:0] ACC_OFF        = 3'h2;  // accessory_write_port
   localparam logic [2:0] AUX_OFF        = 3'h3;  // auxiliary command port
   localparam logic [2:0] EOS_BYTE_OFF   = 3'h6;  // end_string_byte write
   localparam logic [2:0] CTRL_READ_OFF  = 3'h7;  // control readback
   // accessory selector patterns in bits 7..5
   localparam logic [2:0] SEL_EOS_CTRL   = 3'h4;  // 1,0,0
   localparam logic [2:0] SEL_OPTIONS    = 3'h5;  // 1,0,1
   localparam int         SEL_MSB        = 7;
   localparam int         SEL_LSB        = 5;
   // eos_end_control field positions
   localparam int         WIDTH_SEL_BIT  = 4;     // compare_width_select
   localparam int         TX_MATCH_BIT   = 3;     // transmit_end_on_match
   localparam int         RX_MATCH_BIT   = 2;     // receive_end_on_match
   // status_interrupt_options field positions
   localparam int         STAT_SRC_BIT   = 4;     // status_source_select
   localparam int         INT_POL_BIT    = 3;     // interrupt_pin_polarity
   localparam int         LISTEN_CTL_BIT = 2;     // listen_when_controller
   localparam int         POLL_EOI_BIT   = 1;     // serial_poll_eoi_enable
   localparam int         AUTO_TAKE_BIT  = 0;     // auto_take_control
   // status bit position of the end flag
   localparam int         END_STAT_BIT   = 3;
   // reset values
   localparam logic [2:0] EOS_CTRL_RST   = 3'h0;
   localparam logic [4:0] OPTIONS_RST    = 5'h00;
   localparam logic [7:0] EOS_BYTE_RST   = 8'h00;
   // channel reset auxiliary command code
   localparam logic [7:0] AUX_CHAN_RESET = 8'h00;
   // compare masks
   localparam logic [7:0] MASK_8BIT      = 8'hff;
   localparam logic [7:0] MASK_7BIT      = 8'h7f;
endpackage : eec_pkg

/* rtl/eec_eos_match.sv */
// compares one bus byte with the end-of-string byte over 7 or 8 bits
`timescale 1ns/100ps
module eec_eos_match
   import eec_pkg::*;
(
   input  wire logic [7:0] data_byte,   // byte on the bus
   input  wire logic [7:0] eos_byte,    // end-of-string byte
   input  wire logic       width8,      // 1 = 8-bit compare
   output logic            match        // bytes equal under mask
);
   logic [7:0] mask;  // bits taking part in the compare

   // mask out bit 7 in 7-bit mode
   always_comb begin
      mask  = width8 ? MASK_8BIT : MASK_7BIT;   // R3 R4
      match = ((data_byte ^ eos_byte) & mask) == 8'h00;
   end
endmodule : eec_eos_match

/* bench/eec_gpib_peer.sv */
// gpib-side peer model: presents received bytes with optional end line
`timescale 1ns/100ps
module eec_gpib_peer (
   input  wire logic       core_clk,  // chip clock
   output logic            rx_valid,  // byte strobe
   output logic      [7:0] rx_byte,   // data lines
   output logic            rx_eoi     // end line
);
   // idle lines at time zero
   initial begin
      rx_valid = 1'b0;
      rx_byte  = 8'h5a;
      rx_eoi   = 1'b0;
   end
   // one byte per call; released lines show inverse, not stale data
   task automatic send(input logic [7:0] b, input logic e);
      @(posedge core_clk);
      rx_valid <= 1'b1;
      rx_byte  <= b;
      rx_eoi   <= e;
      @(posedge core_clk);
      rx_valid <= 1'b0;
      rx_byte  <= ~b;
      rx_eoi   <= ~e;
   endtask : send
endmodule : eec_gpib_peer

/* bench/eec_top_bench.sv */
// self-checking bench for the end-of-string and option block
`timescale 1ns/100ps
module eec_top_bench;
   import eec_pkg::*;
   logic       core_clk  = 1'b0;  // 25 MHz
   logic       resetn    = 1'b0;  // async, low
   logic [2:0] reg_addr  = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr    = 1'b0;
   logic       reg_rd    = 1'b0;
   logic       talk_act  = 1'b1;  // talker active
   logic       tx_load   = 1'b0;
   logic [7:0] cdo       = 8'h00; // outgoing byte
   logic       spoll     = 1'b0;  // serial poll
   logic       listen_act = 1'b1; // listener active
   logic [4:0] ins       = 5'h00; // {int, cic, own, srq, ppf}
   logic       passed    = 1'b0;  // control passed
   logic [7:0] reg_rdata, rx_byte;
   logic       eoi_out, rx_valid, rx_eoi, rx_end, end_status, int_pin, accept, take, ist;
   int         err_total = 0;
   int         n_tests   = 0;
   // block under test
   eec_top dut (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .talker_active_state(talk_act),
      .tx_load(tx_load), .command_data_out(cdo), .tx_eoi_req(1'b0), .serial_poll_active(spoll),
      .eoi_out(eoi_out), .listener_active(listen_act), .rx_valid(rx_valid), .rx_byte(rx_byte),
      .rx_eoi(rx_eoi), .rx_end(rx_end), .end_status(end_status), .int_request(ins[4]),
      .int_pin(int_pin), .controller_in_charge(ins[3]), .own_command(ins[2]),
      .command_accept(accept), .control_passed(passed), .take_control(take),
      .srq_state(ins[1]), .parallel_poll_flag(ins[0]), .ist(ist));
   // far-side bus peer
   eec_gpib_peer peer (.core_clk(core_clk), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_eoi(rx_eoi));
   // clock
   always #20 core_clk = ~core_clk;
   // compare and count
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // one-cycle register write
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
   endtask : wr
   // read, data checked in the following cycle
   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask : rd
   // send one byte, eoi seen in the next cycle
   task automatic tx(input logic [7:0] b, input logic exp);
      @(posedge core_clk);
      tx_load <= 1'b1;
      cdo     <= b;
      @(posedge core_clk);
      tx_load <= 1'b0;
      #1 chk({7'h00, eoi_out}, {7'h00, exp});
   endtask : tx
   // receive one byte from the peer
   task automatic rx(input logic [7:0] b, input logic e, input logic exp);
      peer.send(b, e);
      #1 chk({6'h00, rx_end, end_status}, {6'h00, exp, exp});
   endtask : rx
   // option write, then {int_pin, accept, ist}
   task automatic opt(input logic [7:0] d, input logic [4:0] i, input logic [2:0] exp);
      @(posedge core_clk);
      ins <= i;
      wr(ACC_OFF, d);
      @(posedge core_clk);
      #1 chk({5'h00, int_pin, accept, ist}, {5'h00, exp});
   endtask : opt
   // control passed pulse
   task automatic tc(input logic [7:0] d, input logic exp);
      wr(ACC_OFF, d);
      @(posedge core_clk);
      passed <= 1'b1;
      @(posedge core_clk);
      passed <= 1'b0;
      #1 chk({7'h00, take}, {7'h00, exp});
   endtask : tc
   // verdict and end of run
   task automatic report_and_stop;
      $display("comparisons=%0d mismatches=%0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop
   // hang guard
   initial begin
      #100000;
      err_total++;
      report_and_stop();
   end
   // main sequence
   initial begin
      repeat (6) @(posedge core_clk);
      resetn <= 1'b1;
      rd(CTRL_READ_OFF, 8'h00);
      rd(STATUS_OFF, 8'h00);
      wr(EOS_BYTE_OFF, 8'hc1);
      wr(ACC_OFF, 8'h9c);
      rd(CTRL_READ_OFF, 8'he0);
      wr(ACC_OFF, 8'h6f);
      wr(ACC_OFF, 8'hd0);
      rd(CTRL_READ_OFF, 8'he0);
      wr(ACC_OFF, 8'hb5);
      rd(CTRL_READ_OFF, 8'hf5);
      wr(AUX_OFF, AUX_CHAN_RESET);
      rd(CTRL_READ_OFF, 8'h15);
      wr(ACC_OFF, 8'h98);
      tx(8'hc1, 1'b1);
      tx(8'h41, 1'b0);
      wr(ACC_OFF, 8'h88);
      tx(8'h41, 1'b1);
      tx(8'h42, 1'b0);
      @(posedge core_clk);
      talk_act <= 1'b0;
      tx(8'hc1, 1'b0);
      wr(ACC_OFF, 8'h84);
      rx(8'h41, 1'b0, 1'b1);
      rd(STATUS_OFF, 8'h08);
      rd(STATUS_OFF, 8'h00);
      rx(8'h42, 1'b1, 1'b1);
      rd(STATUS_OFF, 8'h08);
      wr(ACC_OFF, 8'h80);
      rx(8'hc1, 1'b0, 1'b0);
      opt(8'ha0, 5'b11110, 3'b000);
      opt(8'hbc, 5'b11110, 3'b111);
      opt(8'ha8, 5'b01101, 3'b001);
      tc(8'ha1, 1'b1);
      tc(8'ha0, 1'b0);
      @(posedge core_clk);
      spoll <= 1'b1;
      wr(ACC_OFF, 8'ha2);
      tx(8'h00, 1'b1);
      wr(ACC_OFF, 8'ha0);
      tx(8'h00, 1'b0);
      report_and_stop();
   end
endmodule : eec_top_bench
